// ### pkg/tob_params.svh
`ifndef TOB_PARAMS_SVH
`define TOB_PARAMS_SVH
// Function
// - index 00h,01h,02h,03h,06h selects adc ref, adc/comp, osc, osc/brownout, filter trims
// - index 0 byte at 0020H; bits 7:3 adc reference trim, bits 2:0 hold 111
// - the 0022H byte is all eight bits of oscillator trim
// - 0023H byte: bits 2:0 brownout/oscillator trim, upper bits stay ones
// - brownout code 000=1.7,001=1.6,111=1.8,110=2.0,101=2.2,100=2.4; 010/011 undefined
// - clock filter byte at 0026H, default has only bits 6 and 2 set
// - filter bit 7 clear gives full rate output, set gives quarter rate
// - filter mode 00 off, 01 drops low glitches, 10 drops high glitches, 11 both
// - bits 5:3 pick 5,7,9,11,13,17,20,25 ns; bit 3 is code msb
// - trim bytes keep their contents through every reset
// - trim bytes arrive preloaded with factory values
`define TOB_CLK_PERIOD_NS  50
`define TOB_IDX_ADC_REF    3'h0
`define TOB_IDX_ADC_COMP   3'h1
`define TOB_IDX_OSC        3'h2
`define TOB_IDX_BO         3'h3
`define TOB_IDX_FILT       3'h6
`define TOB_LOAD_LAST      3'h4
`define TOB_REG_INDEX      8'h00
`define TOB_REG_DATA       8'h01
`define TOB_REG_STATUS     8'h02
`define TOB_REG_ADC_REF    8'h20
`define TOB_REG_ADC_COMP   8'h21
`define TOB_REG_OSC        8'h22
`define TOB_REG_BO         8'h23
`define TOB_REG_FILT       8'h26
`define TOB_REG_NONE       8'hFF
`define TOB_ADC_REF_SET    8'h07
`define TOB_BO_SET         8'hF8
`define TOB_FILT_SET       8'h44
`define TOB_FACT_ADC_REF   8'h87
`define TOB_FACT_ADC_COMP  8'hFF
`define TOB_FACT_OSC       8'h80
`define TOB_FACT_BO        8'hF8
`define TOB_FACT_FILT      8'h44
`define TOB_ADC_REF_LSB    3
`define TOB_FILT_DIV_BIT   7
`define TOB_DLY_NS_0       5
`define TOB_DLY_NS_1       7
`define TOB_DLY_NS_2       9
`define TOB_DLY_NS_3       11
`define TOB_DLY_NS_4       13
`define TOB_DLY_NS_5       17
`define TOB_DLY_NS_6       20
`define TOB_DLY_NS_7       25
`define TOB_BO_MV_000      12'h6A4
`define TOB_BO_MV_001      12'h640
`define TOB_BO_MV_111      12'h708
`define TOB_BO_MV_110      12'h7D0
`define TOB_BO_MV_101      12'h898
`define TOB_BO_MV_100      12'h960
`define TOB_RESP_OKAY      2'h0
`define TOB_RESP_SLVERR    2'h2
`endif

// ### pkg/tob_pkg.sv
`include "tob_params.svh"
package tob_pkg;
  typedef logic [7:0] tob_byte_t;
  typedef logic [2:0] tob_idx_t;
  typedef enum logic {st_load, st_run} tob_state_t;
  typedef enum logic [1:0] {filt_none, filt_low, filt_high, filt_both} tob_filt_mode_t;

  function automatic logic tob_defined(input tob_idx_t idx);
    return (idx <= `TOB_IDX_BO) || (idx == `TOB_IDX_FILT);
  endfunction

  // reserved ones are forced so a careless write cannot clear them
  function automatic tob_byte_t tob_fix(input tob_idx_t idx, input tob_byte_t d);
    tob_byte_t r;
    r = d;
    if (idx == `TOB_IDX_ADC_REF) r = d | `TOB_ADC_REF_SET;
    if (idx == `TOB_IDX_BO) r = d | `TOB_BO_SET;
    if (idx == `TOB_IDX_FILT) r = d | `TOB_FILT_SET;
    return r;
  endfunction

  // least pulse width rounds up to whole cycles
  function automatic logic [7:0] tob_dly_cycles(input logic [2:0] code);
    int ns;
    case (code)
      3'h0:    ns = `TOB_DLY_NS_0;
      3'h1:    ns = `TOB_DLY_NS_1;
      3'h2:    ns = `TOB_DLY_NS_2;
      3'h3:    ns = `TOB_DLY_NS_3;
      3'h4:    ns = `TOB_DLY_NS_4;
      3'h5:    ns = `TOB_DLY_NS_5;
      3'h6:    ns = `TOB_DLY_NS_6;
      default: ns = `TOB_DLY_NS_7;
    endcase
    return 8'((ns + `TOB_CLK_PERIOD_NS - 1) / `TOB_CLK_PERIOD_NS);
  endfunction

  function automatic logic [11:0] tob_bo_mv(input logic [2:0] code);
    case (code)
      3'h0:    return `TOB_BO_MV_000;
      3'h1:    return `TOB_BO_MV_001;
      3'h7:    return `TOB_BO_MV_111;
      3'h6:    return `TOB_BO_MV_110;
      3'h5:    return `TOB_BO_MV_101;
      3'h4:    return `TOB_BO_MV_100;
      default: return 12'h000;
    endcase
  endfunction
endpackage

// ### src/tob_trim_store.sv
`include "tob_params.svh"
module tob_trim_store #(
  parameter logic [7:0] FACT_ADC_REF  = `TOB_FACT_ADC_REF,
  parameter logic [7:0] FACT_ADC_COMP = `TOB_FACT_ADC_COMP,
  parameter logic [7:0] FACT_OSC      = `TOB_FACT_OSC,
  parameter logic [7:0] FACT_BO       = `TOB_FACT_BO
) (
  input  wire logic               core_clk,
  input  wire logic               wr_en,
  input  wire tob_pkg::tob_idx_t  wr_idx,
  input  wire tob_pkg::tob_byte_t wr_data,
  input  wire tob_pkg::tob_idx_t  rd_idx,
  output tob_pkg::tob_byte_t      rd_data
);
  import tob_pkg::*;
  // no reset term: contents model nonvolatile cells
  tob_byte_t mem [0:7] = '{FACT_ADC_REF, FACT_ADC_COMP, FACT_OSC, FACT_BO,
                           8'hFF, 8'hFF, `TOB_FACT_FILT, 8'hFF};

  always_ff @(posedge core_clk) begin
    if (wr_en && tob_defined(wr_idx)) begin
      mem[wr_idx] <= tob_fix(wr_idx, wr_data);
    end
  end

  assign rd_data = tob_defined(rd_idx) ? mem[rd_idx] : 8'h00;
endmodule // tob_trim_store

// ### src/tob_clk_filter.sv
`include "tob_params.svh"
module tob_clk_filter (
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  input  wire logic                    clk_in,
  input  wire logic                    div_sel,
  input  wire logic [2:0]              dly_code,
  input  wire tob_pkg::tob_filt_mode_t mode,
  output logic                         clk_out
);
  import tob_pkg::*;
  logic       sync_a;
  logic       sync_b;
  logic       level;
  logic [7:0] run;
  logic [1:0] div_cnt;

  // at 50 ns sampling every width collapses to one cycle
  wire [7:0] hold_cyc  = tob_dly_cycles(dly_code);
  wire       drop_low  = (mode == filt_low) || (mode == filt_both);
  wire       drop_high = (mode == filt_high) || (mode == filt_both);
  wire       suppress  = level ? drop_low : drop_high;
  wire       differs   = sync_b != level;
  wire       accept    = differs && (!suppress || run >= hold_cyc);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync_a  <= 1'b0;
      sync_b  <= 1'b0;
      level   <= 1'b0;
      run     <= 8'h00;
      div_cnt <= 2'h0;
      clk_out <= 1'b0;
    end else begin
      sync_a  <= clk_in;
      sync_b  <= sync_a;
      run     <= (differs && !accept) ? 8'(run + 8'h01) : 8'h00;
      level   <= accept ? sync_b : level;
      div_cnt <= (accept && sync_b) ? 2'(div_cnt + 2'h1) : div_cnt;
      clk_out <= div_sel ? div_cnt[1] : level;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_full_rate;
    !div_sel |=> clk_out == $past(level);
  endproperty
  a_full_rate: assert property (p_full_rate) else $error("full rate output wrong");

  property p_no_filter;
    (mode == filt_none && differs) |=> level == $past(sync_b);
  endproperty
  a_no_filter: assert property (p_no_filter) else $error("unfiltered edge held");

  property p_short_pulse;
    (suppress && differs && run < hold_cyc) |=> level == $past(level);
  endproperty
  a_short_pulse: assert property (p_short_pulse) else $error("short pulse passed");
endmodule // tob_clk_filter

// ### src/tob_trim_bank.sv
// Implementation choice: the AXI4-Lite slave port.
`include "tob_params.svh"
module tob_trim_bank #(
  parameter int ADDR_W = 12
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              clk_in,
  output logic                   filtered_clk,
  output logic [4:0]             adc_ref_trim_field,
  output tob_pkg::tob_byte_t     adc_comparator_trim,
  output tob_pkg::tob_byte_t     osc_trim_field,
  output logic [2:0]             brownout_level_field,
  output logic [11:0]            brownout_level_mv,
  output logic                   brownout_level_valid,
  output logic                   trim_load_done
);
  import tob_pkg::*;

  if (ADDR_W < 10) begin : g_bad_addr_w
    $error("ADDR_W must be at least 10");
  end

  // register index from a byte address; anything above the map is unmapped
  function automatic logic [7:0] tob_word(input logic [ADDR_W-1:0] a);
    return ((a >> 10) == '0) ? a[9:2] : `TOB_REG_NONE;
  endfunction

  // {hit, store index} for a register index
  function automatic logic [3:0] tob_map(input logic [7:0] ri, input tob_idx_t sel);
    case (ri)
      `TOB_REG_ADC_REF:  return {1'b1, `TOB_IDX_ADC_REF};
      `TOB_REG_ADC_COMP: return {1'b1, `TOB_IDX_ADC_COMP};
      `TOB_REG_OSC:      return {1'b1, `TOB_IDX_OSC};
      `TOB_REG_BO:       return {1'b1, `TOB_IDX_BO};
      `TOB_REG_FILT:     return {1'b1, `TOB_IDX_FILT};
      `TOB_REG_DATA:     return {tob_defined(sel), sel};
      default:           return 4'h0;
    endcase
  endfunction

  tob_state_t        state;
  logic [2:0]        load_ptr;
  tob_idx_t          trim_index;
  logic [ADDR_W-1:0] aw_addr;
  tob_byte_t         w_byte;
  logic              w_lane0;
  logic              quarter_rate_select;
  logic [2:0]        pulse_delay_ctl;
  tob_filt_mode_t    glitch_filter_select;
  logic              rd_trim_q;
  tob_idx_t          rd_idx_q;
  tob_byte_t         store_rd;

  wire [7:0]  ar_ri    = tob_word(s_axi_araddr);
  wire [7:0]  aw_ri    = tob_word(aw_addr);
  wire [3:0]  ar_map   = tob_map(ar_ri, trim_index);
  wire [3:0]  aw_map   = tob_map(aw_ri, trim_index);
  wire        ar_own   = (ar_ri == `TOB_REG_INDEX) || (ar_ri == `TOB_REG_STATUS);
  wire        aw_own   = (aw_ri == `TOB_REG_INDEX) || (aw_ri == `TOB_REG_STATUS);
  wire        loading  = state == st_load;
  wire        load_end = loading && (load_ptr == `TOB_LOAD_LAST);
  wire        ar_fire  = s_axi_arvalid && s_axi_arready;
  wire        wr_fire  = !loading && !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire        wr_trim  = wr_fire && aw_map[3] && w_lane0;
  wire        wr_index = wr_fire && (aw_ri == `TOB_REG_INDEX) && w_lane0;

  // load order 0,1,2,3 then the filter byte at 6
  wire tob_idx_t  load_idx   = (load_ptr == `TOB_LOAD_LAST) ? `TOB_IDX_FILT : load_ptr;
  wire tob_idx_t  st_rd_idx  = loading ? load_idx : ar_map[2:0];
  wire tob_byte_t fixed_w    = tob_fix(aw_map[2:0], w_byte);
  wire            apply_en   = loading || wr_trim;
  wire tob_idx_t  apply_idx  = loading ? load_idx : aw_map[2:0];
  wire tob_byte_t apply_data = loading ? store_rd : fixed_w;
  wire [1:0]      ar_resp    = (ar_map[3] || ar_own) ? `TOB_RESP_OKAY : `TOB_RESP_SLVERR;
  wire [1:0]      aw_resp    = (aw_map[3] || aw_own) ? `TOB_RESP_OKAY : `TOB_RESP_SLVERR;
  wire [31:0]     rd_word    = (ar_ri == `TOB_REG_INDEX)  ? {29'h0, trim_index} :
                               (ar_ri == `TOB_REG_STATUS) ? {31'h0, trim_load_done} :
                               ar_map[3]                  ? {24'h0, store_rd} : 32'h0;

  tob_trim_store u_store (
    .core_clk (core_clk),
    .wr_en    (wr_trim),
    .wr_idx   (aw_map[2:0]),
    .wr_data  (w_byte),
    .rd_idx   (st_rd_idx),
    .rd_data  (store_rd)
  );

  tob_clk_filter u_filter (
    .core_clk (core_clk),
    .rst      (rst),
    .clk_in   (clk_in),
    .div_sel  (quarter_rate_select),
    .dly_code (pulse_delay_ctl),
    .mode     (glitch_filter_select),
    .clk_out  (filtered_clk)
  );

  // write channel: address and data held until the response is taken
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `TOB_RESP_OKAY;
      aw_addr       <= '0;
      w_byte        <= 8'h00;
      w_lane0       <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_byte       <= s_axi_wdata[7:0];
        w_lane0      <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= aw_resp;
      end
      if (load_end || (s_axi_bvalid && s_axi_bready)) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // read channel: data captured at the address handshake
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `TOB_RESP_OKAY;
      rd_trim_q     <= 1'b0;
      rd_idx_q      <= 3'h0;
    end else begin
      if (ar_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= ar_resp;
        rd_trim_q     <= ar_map[3];
        rd_idx_q      <= ar_map[2:0];
      end
      if (load_end || (s_axi_rvalid && s_axi_rready)) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // bus stays closed while trims are copied out, so the store port is free
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state          <= st_load;
      load_ptr       <= 3'h0;
      trim_load_done <= 1'b0;
      trim_index     <= 3'h0;
    end else begin
      if (loading) begin
        load_ptr <= 3'(load_ptr + 3'h1);
      end
      if (load_end) begin
        state          <= st_run;
        trim_load_done <= 1'b1;
      end
      if (wr_index) begin
        trim_index <= w_byte[2:0];
      end
    end
  end

  // consumer registers; contents are reloaded from the store after each reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      adc_ref_trim_field   <= 5'h00;
      adc_comparator_trim  <= 8'h00;
      osc_trim_field       <= 8'h00;
      brownout_level_field <= 3'h0;
      brownout_level_mv    <= 12'h000;
      brownout_level_valid <= 1'b0;
      quarter_rate_select  <= 1'b0;
      pulse_delay_ctl      <= 3'h0;
      glitch_filter_select <= filt_none;
    end else if (apply_en) begin
      case (apply_idx)
        `TOB_IDX_ADC_REF: begin
          adc_ref_trim_field <= apply_data[`TOB_ADC_REF_LSB +: 5];
        end
        `TOB_IDX_ADC_COMP: begin
          adc_comparator_trim <= apply_data;
        end
        `TOB_IDX_OSC: begin
          osc_trim_field <= apply_data;
        end
        `TOB_IDX_BO: begin
          brownout_level_field <= apply_data[2:0];
          brownout_level_mv    <= tob_bo_mv(apply_data[2:0]);
          brownout_level_valid <= tob_bo_mv(apply_data[2:0]) != 12'h000;
        end
        `TOB_IDX_FILT: begin
          quarter_rate_select  <= apply_data[`TOB_FILT_DIV_BIT];
          pulse_delay_ctl      <= {apply_data[3], apply_data[4], apply_data[5]};
          glitch_filter_select <= tob_filt_mode_t'(apply_data[1:0]);
        end
        default: begin
        end
      endcase
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_load_last;
    loading && load_ptr == `TOB_LOAD_LAST;
  endsequence

  sequence s_bus_open;
    trim_load_done && s_axi_arready && s_axi_awready && s_axi_wready;
  endsequence

  property p_load_done;
    s_load_last |=> s_bus_open;
  endproperty
  a_load_done: assert property (p_load_done) else $error("bus not opened after load");

  property p_index_filter;
    (wr_trim && aw_ri == `TOB_REG_DATA && trim_index == `TOB_IDX_FILT)
      |=> quarter_rate_select == $past(w_byte[`TOB_FILT_DIV_BIT]);
  endproperty
  a_index_filter: assert property (p_index_filter) else $error("indexed filter write lost");

  property p_adc_ref_ones;
    (s_axi_rvalid && rd_trim_q && rd_idx_q == `TOB_IDX_ADC_REF) |-> s_axi_rdata[2:0] == 3'h7;
  endproperty
  a_adc_ref_ones: assert property (p_adc_ref_ones) else $error("adc ref low bits not ones");

  property p_osc_copy;
    (wr_trim && aw_map[2:0] == `TOB_IDX_OSC) |=> osc_trim_field == $past(w_byte);
  endproperty
  a_osc_copy: assert property (p_osc_copy) else $error("oscillator trim not taken");

  property p_bo_ones;
    (s_axi_rvalid && rd_trim_q && rd_idx_q == `TOB_IDX_BO) |-> s_axi_rdata[7:3] == 5'h1F;
  endproperty
  a_bo_ones: assert property (p_bo_ones) else $error("brownout upper bits not ones");

  property p_bo_level;
    trim_load_done |-> ((brownout_level_field[2:1] == 2'h1) == !brownout_level_valid);
  endproperty
  a_bo_level: assert property (p_bo_level) else $error("brownout validity wrong");

  property p_filt_ones;
    (s_axi_rvalid && rd_trim_q && rd_idx_q == `TOB_IDX_FILT) |-> s_axi_rdata[6] && s_axi_rdata[2];
  endproperty
  a_filt_ones: assert property (p_filt_ones) else $error("filter reserved bits not ones");

  property p_resp_hold;
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_resp_hold: assert property (p_resp_hold) else $error("write response dropped");
endmodule // tob_trim_bank

// ### verification/tob_trim_bank_tb.sv
`include "tob_params.svh"
module tob_trim_bank_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import tob_pkg::*;

  logic        core_clk      = 1'b0;
  logic        rst           = 1'b1;
  logic [11:0] s_axi_awaddr  = 12'h000;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata   = 32'h0;
  logic [3:0]  s_axi_wstrb   = 4'h0;
  logic        s_axi_wvalid  = 1'b0;
  logic        s_axi_bready  = 1'b0;
  logic [11:0] s_axi_araddr  = 12'h000;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready  = 1'b0;
  logic        clk_in        = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        filtered_clk, brownout_level_valid, trim_load_done, fc_q;
  logic [4:0]  adc_ref_trim_field;
  tob_byte_t   adc_comparator_trim, osc_trim_field;
  logic [2:0]  brownout_level_field;
  logic [11:0] brownout_level_mv;
  int          mismatches = 0;
  int          n_tests    = 0;
  int          seed       = 12;
  int          rises      = 0;
  int          falls      = 0;
  logic        counting   = 1'b0;
  logic [33:0] rd_q[$];
  logic [1:0]  wr_q[$];
  tob_byte_t   mdl[8]     = '{`TOB_FACT_ADC_REF, `TOB_FACT_ADC_COMP, `TOB_FACT_OSC, `TOB_FACT_BO,
                              8'h00, 8'h00, `TOB_FACT_FILT, 8'h00};
  logic [11:0] mv_tab[8]  = '{`TOB_BO_MV_000, `TOB_BO_MV_001, 12'h000, 12'h000,
                              `TOB_BO_MV_100, `TOB_BO_MV_101, `TOB_BO_MV_110, `TOB_BO_MV_111};
  tob_byte_t   d;

  tob_trim_bank u_dut (.core_clk(core_clk), .rst(rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .clk_in(clk_in),
    .filtered_clk(filtered_clk), .adc_ref_trim_field(adc_ref_trim_field),
    .adc_comparator_trim(adc_comparator_trim), .osc_trim_field(osc_trim_field),
    .brownout_level_field(brownout_level_field), .brownout_level_mv(brownout_level_mv),
    .brownout_level_valid(brownout_level_valid), .trim_load_done(trim_load_done));

  initial begin
    forever #25 core_clk = ~core_clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  function automatic logic [11:0] adr(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  // bus results are compared where they appear, against the oldest note
  always @(posedge core_clk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      check("rdata", s_axi_rdata, rd_q[0][31:0]);
      check("rresp", {30'h0, s_axi_rresp}, {30'h0, rd_q[0][33:32]});
      void'(rd_q.pop_front());
    end
    if (s_axi_bvalid && s_axi_bready) begin
      check("bresp", {30'h0, s_axi_bresp}, {30'h0, wr_q[0]});
      void'(wr_q.pop_front());
    end
  end

  always @(posedge core_clk) begin
    if (counting && filtered_clk && !fc_q) rises <= rises + 1;
    if (counting && !filtered_clk && fc_q) falls <= falls + 1;
    fc_q <= filtered_clk;
  end

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] resp);
    rd_q.push_back({resp, e});
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge core_clk);
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [11:0] a, input tob_byte_t v, input logic [3:0] strb,
                    input logic [1:0] resp);
    logic aw_d;
    logic w_d;
    aw_d = 1'b0;
    w_d  = 1'b0;
    wr_q.push_back(resp);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= {24'h0, v};
    s_axi_wstrb   <= strb;
    s_axi_wvalid  <= 1'b1;
    while (!(aw_d && w_d)) begin
      @(posedge core_clk);
      if (s_axi_awready && !aw_d) begin
        aw_d = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !w_d) begin
        w_d = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    // late ready leaves a pending response on the bus for a cycle
    repeat (2) @(posedge core_clk);
    s_axi_bready <= 1'b1;
    do @(posedge core_clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic chk_cons;
    check("adc_ref", {27'h0, adc_ref_trim_field}, {27'h0, mdl[0][7:3]});
    check("adc_comp", {24'h0, adc_comparator_trim}, {24'h0, mdl[1]});
    check("osc", {24'h0, osc_trim_field}, {24'h0, mdl[2]});
    check("bo_field", {29'h0, brownout_level_field}, {29'h0, mdl[3][2:0]});
    check("bo_mv", {20'h0, brownout_level_mv}, {20'h0, mv_tab[mdl[3][2:0]]});
    check("bo_valid", {31'h0, brownout_level_valid}, {31'h0, mdl[3][2:1] != 2'b01});
  endtask

  task automatic do_reset;
    rst <= 1'b1;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 20 && trim_load_done !== 1'b1; i++) @(posedge core_clk);
    check("load_done", {31'h0, trim_load_done}, 32'h1);
    for (int i = 0; i < 8; i++) begin
      if (i != 4 && i != 5 && i != 7) rd(adr(8'h20 + 8'(i)), {24'h0, mdl[i]}, `TOB_RESP_OKAY);
    end
    chk_cons();
  endtask

  // one-cycle pulse on each polarity; only a lasting level may pass a suppressing mode
  task automatic glitch(input logic [7:0] fb);
    wr(adr(`TOB_REG_FILT), fb, 4'h1, `TOB_RESP_OKAY);
    repeat (10) @(posedge core_clk);
    rises <= 0;
    falls <= 0;
    counting <= 1'b1;
    clk_in <= 1'b1;
    @(posedge core_clk);
    clk_in <= 1'b0;
    repeat (10) @(posedge core_clk);
    check("high_glitch", rises, {31'h0, !fb[1]});
    clk_in <= 1'b1;
    repeat (10) @(posedge core_clk);
    clk_in <= 1'b0;
    @(posedge core_clk);
    clk_in <= 1'b1;
    repeat (10) @(posedge core_clk);
    check("low_glitch", falls, {31'h0, !fb[0]} + {31'h0, !fb[1]});
    counting <= 1'b0;
    clk_in <= 1'b0;
    repeat (10) @(posedge core_clk);
  endtask

  task automatic rate(input logic div, input int exp);
    wr(adr(`TOB_REG_FILT), {div, 7'h44}, 4'h1, `TOB_RESP_OKAY);
    repeat (10) @(posedge core_clk);
    rises <= 0;
    counting <= 1'b1;
    repeat (16) begin
      clk_in <= 1'b1;
      repeat (4) @(posedge core_clk);
      clk_in <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
    repeat (10) @(posedge core_clk);
    counting <= 1'b0;
    check("out_rate", rises, exp);
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    report_and_stop();
  end

  initial begin
    do_reset();
    rd(adr(`TOB_REG_STATUS), 32'h1, `TOB_RESP_OKAY);
    rd(12'h400, 32'h0, `TOB_RESP_SLVERR);
    // comparator trim is never written by software
    d = 8'($random(seed));
    mdl[0] = d | 8'h07;
    wr(adr(`TOB_REG_ADC_REF), d & 8'hF8, 4'h1, `TOB_RESP_OKAY);
    d = 8'($random(seed));
    mdl[2] = d;
    wr(adr(`TOB_REG_OSC), d, 4'h1, `TOB_RESP_OKAY);
    for (int c = 0; c < 8; c++) begin
      d = 8'($random(seed));
      mdl[3] = {5'h1F, 3'(c)};
      wr(adr(`TOB_REG_BO), {d[7:3], 3'(c)}, 4'h1, `TOB_RESP_OKAY);
      chk_cons();
    end
    rd(adr(`TOB_REG_BO), {24'h0, mdl[3]}, `TOB_RESP_OKAY);
    wr(adr(`TOB_REG_INDEX), 8'h06, 4'h1, `TOB_RESP_OKAY);
    rd(adr(`TOB_REG_DATA), {24'h0, mdl[6]}, `TOB_RESP_OKAY);
    wr(adr(`TOB_REG_DATA), 8'hC4, 4'h1, `TOB_RESP_OKAY);
    rd(adr(`TOB_REG_FILT), 32'hC4, `TOB_RESP_OKAY);
    wr(adr(`TOB_REG_INDEX), 8'h02, 4'h1, `TOB_RESP_OKAY);
    d = 8'($random(seed));
    mdl[2] = d;
    wr(adr(`TOB_REG_DATA), d, 4'h1, `TOB_RESP_OKAY);
    rd(adr(`TOB_REG_OSC), {24'h0, d}, `TOB_RESP_OKAY);
    wr(adr(`TOB_REG_INDEX), 8'h04, 4'h1, `TOB_RESP_OKAY);
    wr(adr(`TOB_REG_DATA), d, 4'h1, `TOB_RESP_SLVERR);
    wr(adr(`TOB_REG_STATUS), 8'h00, 4'h1, `TOB_RESP_OKAY);
    rd(adr(`TOB_REG_STATUS), 32'h1, `TOB_RESP_OKAY);
    wr(12'h400, 8'h00, 4'h1, `TOB_RESP_SLVERR);
    wr(adr(`TOB_REG_OSC), ~d, 4'hE, `TOB_RESP_OKAY);
    rd(adr(`TOB_REG_OSC), {24'h0, d}, `TOB_RESP_OKAY);
    chk_cons();
    // every mode twice and every delay code once
    for (int i = 0; i < 8; i++) glitch({2'b01, 3'(i), 1'b1, 2'(i)});
    rate(1'b1, 4);
    rate(1'b0, 16);
    mdl[6] = 8'h44;
    do_reset();
    report_and_stop();
  end
endmodule // tob_trim_bank_tb
